// file: hw/guard_timer.sv
/*
 * Watchdog and interval timer with password-protected word writes.
 * Assumes a CPU port synchronous to clk; reset is the chip pin reset.
 */
// Operation
// - Overflow in watchdog mode sets the guard reset flag.
// - Flag cleared by read-as-one then write zero, or by pin reset.
// - Flag and output enable reset only by the pin, not watchdog.
// - Reset-out pin pulled low only when output enable is one.
// - Six low reserved bits read one, writes ignored.
// - Counter and control writes need word access; byte writes ignored.
// - Upper byte password 5A selects counter, A5 selects control.
// - Reset register word A5/00 clears the guard reset flag.
// - Reset register word with 5A loads output enable bit.
// - Byte reads of all three registers need no password.
// - Watchdog overflow holds chip in internal reset 518 states.
// - Reset-out pulse lasts 132 states when enabled.
// - Watchdog reset shares the pin-reset vector; flag tells them apart.
// - Pin reset wins over a simultaneous watchdog reset.
// - Interval mode requests an interrupt while overflow flag is set; the code also requires count_run to be one.
// - Overflow flag sets in the overflow cycle with reset or irq.
// - Internal reset clears overflow flag, keeps guard reset flag.
// - A counter write beats a coincident increment.
// - Counter clock is one of eight prescaled sources.
// - Overflow is the wrap from FF to 00.
// - Counter held at 00 while count_run is zero.
`timescale 1ns/1ps
`default_nettype none
module guard_timer
    import guard_timer_pkg::*;
(
    // Clock and pin reset
    input wire logic clk,
    input wire logic reset,
    // CPU access
    input wire cpu_req_t cpu,
    output logic [7:0] rdata,
    // Chip reset and interrupt
    output logic chip_reset,
    output logic reset_out_pin_n,
    output logic reset_out_oe,
    output logic interval_irq
);

    ////////////////////////////////////////////////////////////////////////
    // State
    logic overflow_flag_q, overflow_flag_d;
    logic mode_select_q, mode_select_d;
    logic count_run_q, count_run_d;
    logic [2:0] clock_select_q, clock_select_d;
    logic [7:0] timer_count_q, timer_count_d;
    logic guard_reset_flag_q, guard_reset_flag_d;
    logic reset_output_enable_q, reset_output_enable_d;
    logic overflow_seen_q, overflow_seen_d;
    logic grf_seen_q, grf_seen_d;
    rst_state_t rst_state_q, rst_state_d;
    logic [9:0] rst_cnt_q, rst_cnt_d;
    logic ext_on_q, ext_on_d;
    logic [7:0] rdata_q, rdata_d;

    logic tick;
    logic wr_timer;
    logic wr_count;
    logic wr_ctrl;
    logic wr_reset;
    logic overflow;
    logic wd_fire;
    logic internal_reset;
    logic [7:0] tcs_view;
    logic [7:0] rcs_view;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler
    guard_prescaler u_prescaler (
        .clk(clk),
        .reset(reset),
        .clock_select(clock_select_q),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write decode: only word writes with a valid password take effect
    always_comb
    begin
        wr_timer = cpu.wr && cpu.word && (cpu.addr == ADDR_TIMER_WR);
        wr_reset = cpu.wr && cpu.word && (cpu.addr == ADDR_RESET_WR);
        wr_count = wr_timer && (cpu.wdata[15:8] == PASS_COUNT);
        wr_ctrl = wr_timer && (cpu.wdata[15:8] == PASS_CTRL);
    end

    // Register views; reserved bits always read as one
    always_comb
    begin
        tcs_view = {overflow_flag_q, mode_select_q, count_run_q, TCS_RSVD_ONES, clock_select_q};
        rcs_view = {guard_reset_flag_q, reset_output_enable_q, RCS_RSVD_ONES};
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter and overflow detection
    always_comb
    begin
        overflow = count_run_q && tick && !wr_count && (timer_count_q == CNT_WRAP);
        wd_fire = overflow && mode_select_q && count_run_q;
        internal_reset = (rst_state_q == ST_HOLD);
        timer_count_d = timer_count_q;
        // A halted counter ignores writes, so a stray write cannot leave it armed
        if (internal_reset)
            timer_count_d = CNT_RESET;
        else if (!count_run_q)
            timer_count_d = CNT_RESET;
        else if (wr_count)
            timer_count_d = cpu.wdata[7:0];
        else if (tick)
            timer_count_d = timer_count_q + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer control/status; internal reset restores it like the pin reset
    always_comb
    begin
        overflow_flag_d = overflow_flag_q;
        mode_select_d = mode_select_q;
        count_run_d = count_run_q;
        clock_select_d = clock_select_q;
        overflow_seen_d = overflow_seen_q;
        if (cpu.rd && (cpu.addr == ADDR_TCS_RD))
            overflow_seen_d = overflow_flag_q;
        if (internal_reset)
        begin
            overflow_flag_d = TCS_RESET[OVERFLOW_BIT];
            mode_select_d = TCS_RESET[MODE_BIT];
            count_run_d = TCS_RESET[RUN_BIT];
            clock_select_d = TCS_RESET[2:0];
            overflow_seen_d = 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                mode_select_d = cpu.wdata[MODE_BIT];
                count_run_d = cpu.wdata[RUN_BIT];
                clock_select_d = cpu.wdata[2:0];
                if (!cpu.wdata[OVERFLOW_BIT] && overflow_seen_q)
                begin
                    overflow_flag_d = 1'b0;
                    overflow_seen_d = 1'b0;
                end
            end
            // Set wins over a clear in the same cycle
            if (overflow)
                overflow_flag_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset control/status; only the pin reset initialises it
    always_comb
    begin
        guard_reset_flag_d = guard_reset_flag_q;
        reset_output_enable_d = reset_output_enable_q;
        grf_seen_d = grf_seen_q;
        if (cpu.rd && (cpu.addr == ADDR_RCS_RD))
            grf_seen_d = guard_reset_flag_q;
        if (wr_reset && (cpu.wdata[15:8] == PASS_CTRL) && (cpu.wdata[7:0] == CLEAR_DATA)
            && grf_seen_q)
        begin
            guard_reset_flag_d = 1'b0;
            grf_seen_d = 1'b0;
        end
        if (wr_reset && (cpu.wdata[15:8] == PASS_COUNT))
            reset_output_enable_d = cpu.wdata[ROE_BIT];
        // Flag survives the internal reset so the handler can tell the causes apart
        if (wd_fire)
            guard_reset_flag_d = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset sequencer: internal hold and external pulse counted in states
    always_comb
    begin
        rst_state_d = rst_state_q;
        rst_cnt_d = rst_cnt_q;
        ext_on_d = ext_on_q;
        case (rst_state_q)
            ST_IDLE:
            begin
                if (wd_fire)
                begin
                    rst_state_d = ST_HOLD;
                    rst_cnt_d = INT_RESET_CYCLES - 10'd1;
                    ext_on_d = reset_output_enable_q;
                end
            end
            ST_HOLD:
            begin
                rst_cnt_d = rst_cnt_q - 10'd1;
                // External pulse ends after its shorter count
                if (rst_cnt_q == (INT_RESET_CYCLES - EXT_RESET_CYCLES))
                    ext_on_d = 1'b0;
                if (rst_cnt_q == 10'd0)
                begin
                    rst_state_d = ST_DONE;
                    ext_on_d = 1'b0;
                end
            end
            ST_DONE:
                rst_state_d = ST_IDLE;
            default:
            begin
                rst_state_d = ST_IDLE;
                ext_on_d = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data: byte reads at separate addresses, no password
    always_comb
    begin
        rdata_d = rdata_q;
        if (cpu.rd)
        begin
            case (cpu.addr)
                ADDR_TCS_RD: rdata_d = tcs_view;
                ADDR_CNT_RD: rdata_d = timer_count_q;
                ADDR_RCS_RD: rdata_d = rcs_view;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers; the pin reset is asynchronous and outranks any watchdog event
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            overflow_flag_q <= TCS_RESET[OVERFLOW_BIT];
            mode_select_q <= TCS_RESET[MODE_BIT];
            count_run_q <= TCS_RESET[RUN_BIT];
            clock_select_q <= TCS_RESET[2:0];
            timer_count_q <= CNT_RESET;
            guard_reset_flag_q <= RCS_RESET[GRF_BIT];
            reset_output_enable_q <= RCS_RESET[ROE_BIT];
            overflow_seen_q <= 1'b0;
            grf_seen_q <= 1'b0;
            rst_state_q <= ST_IDLE;
            rst_cnt_q <= 10'd0;
            ext_on_q <= 1'b0;
            rdata_q <= 8'h00;
        end
        else
        begin
            overflow_flag_q <= overflow_flag_d;
            mode_select_q <= mode_select_d;
            count_run_q <= count_run_d;
            clock_select_q <= clock_select_d;
            timer_count_q <= timer_count_d;
            guard_reset_flag_q <= guard_reset_flag_d;
            reset_output_enable_q <= reset_output_enable_d;
            overflow_seen_q <= overflow_seen_d;
            grf_seen_q <= grf_seen_d;
            rst_state_q <= rst_state_d;
            rst_cnt_q <= rst_cnt_d;
            ext_on_q <= ext_on_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; reset-out is open drain, driven only while low
    always_comb
    begin
        rdata = rdata_q;
        chip_reset = internal_reset;
        reset_out_pin_n = 1'b0;
        reset_out_oe = ext_on_q;
        interval_irq = overflow_flag_q && !mode_select_q && count_run_q;
    end

endmodule : guard_timer
`default_nettype wire

// file: common/guard_timer_pkg.sv
/*
 * Constants and carrier types for the guard timer (watchdog / interval timer).
 * Assumes a single 10 MHz system clock; one state equals one clock cycle.
 */
package guard_timer_pkg;

    // Register addresses (lower 16 bits of the CPU address)
    localparam logic [15:0] ADDR_TCS_RD = 16'hFFA8;
    localparam logic [15:0] ADDR_CNT_RD = 16'hFFA9;
    localparam logic [15:0] ADDR_RCS_RD = 16'hFFAB;
    localparam logic [15:0] ADDR_TIMER_WR = 16'hFFA8;
    localparam logic [15:0] ADDR_RESET_WR = 16'hFFAA;

    // Write passwords and data
    localparam logic [7:0] PASS_COUNT = 8'h5A;
    localparam logic [7:0] PASS_CTRL = 8'hA5;
    localparam logic [7:0] CLEAR_DATA = 8'h00;

    // Field positions of timer_control_status
    localparam int OVERFLOW_BIT = 7;
    localparam int MODE_BIT = 6;
    localparam int RUN_BIT = 5;
    // Field positions of reset_control_status
    localparam int GRF_BIT = 7;
    localparam int ROE_BIT = 6;

    // Values after reset, reserved-bit values and the counter wrap value
    localparam logic [7:0] TCS_RESET = 8'h18;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] RCS_RESET = 8'h3F;
    localparam logic [1:0] TCS_RSVD_ONES = 2'h3;
    localparam logic [5:0] RCS_RSVD_ONES = 6'h3F;
    localparam logic [7:0] CNT_WRAP = 8'hFF;

    // Durations in states
    localparam int STATE_NS = 100;
    localparam int CLK_PERIOD_NS = 100;
    localparam int INT_RESET_STATES = 518;
    localparam int EXT_RESET_STATES = 132;
    localparam logic [9:0] INT_RESET_CYCLES = 10'((INT_RESET_STATES * STATE_NS) / CLK_PERIOD_NS);
    localparam logic [9:0] EXT_RESET_CYCLES = 10'((EXT_RESET_STATES * STATE_NS) / CLK_PERIOD_NS);

    // Prescaler: divide-by exponents for the eight clock_select codes
    localparam int PRE_WIDTH = 12;
    localparam logic [3:0] DIV_EXP [8] = '{4'h1, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hB, 4'hC};

    // CPU access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } cpu_req_t;

    // Reset sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HOLD = 3'b010,
        ST_DONE = 3'b100
    } rst_state_t;

endpackage : guard_timer_pkg

// file: hw/guard_prescaler.sv
/*
 * Free-running prescaler giving one-cycle count enables at phi/2 .. phi/4096.
 * Assumes the system clock and asynchronous active-high reset of the timer.
 */
`timescale 1ns/1ps
`default_nettype none
module guard_prescaler
    import guard_timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Selection and output
    input wire logic [2:0] clock_select,
    output logic tick
);

    logic [PRE_WIDTH-1:0] div_q;
    logic [PRE_WIDTH-1:0] div_d;
    logic [PRE_WIDTH-1:0] mask;

    ////////////////////////////////////////////////////////////////////////
    // Divider; a tick fires when the selected low bits are all ones, the cycle before they wrap to zero
    always_comb
    begin
        div_d = div_q + 1'b1;
        mask = PRE_WIDTH'((13'h1 << DIV_EXP[clock_select]) - 13'h1);
        tick = ((div_q & mask) == mask);
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            div_q <= '0;
        else
            div_q <= div_d;
    end

endmodule : guard_prescaler
`default_nettype wire

// file: sim/guard_timer_checker.sv
/*
 * Port checker for the guard timer: reset pulse lengths, interrupt, reads.
 * Assumes it is bound to guard_timer and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none
module guard_timer_checker
    import guard_timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Watched ports
    input wire cpu_req_t cpu,
    input wire logic [7:0] rdata,
    input wire logic chip_reset,
    input wire logic reset_out_pin_n,
    input wire logic reset_out_oe,
    input wire logic interval_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////////
    // Pulse lengths are too long for repetition, so they are counted here
    logic [9:0] oe_len_q, oe_len_d, rst_len_q, rst_len_d;
    always_comb
    begin
        oe_len_d = reset_out_oe ? oe_len_q + 10'h001 : 10'h000;
        rst_len_d = chip_reset ? rst_len_q + 10'h001 : 10'h000;
    end
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            oe_len_q <= 10'h000;
            rst_len_q <= 10'h000;
        end
        else
        begin
            oe_len_q <= oe_len_d;
            rst_len_q <= rst_len_d;
        end
    end
    // Only a control write may drop the interrupt; reads of other places give zero
    wire logic ctrl_wr = cpu.wr && cpu.word && cpu.addr == ADDR_TIMER_WR
        && cpu.wdata[15:8] == PASS_CTRL;
    wire logic mapped = cpu.addr == ADDR_TCS_RD || cpu.addr == ADDR_CNT_RD
        || cpu.addr == ADDR_RCS_RD;
    ////////////////////////////////////////////////////////////////////////////////
    a_int_reset_len: assert property (
        $fell(chip_reset) |-> rst_len_q == INT_RESET_CYCLES)
        else $error("internal reset length wrong");
    a_int_reset_max: assert property (rst_len_q <= INT_RESET_CYCLES)
        else $error("internal reset too long");
    a_out_pulse_len: assert property (
        $fell(reset_out_oe) |-> oe_len_q == EXT_RESET_CYCLES)
        else $error("reset-out length wrong");
    a_out_starts: assert property ($rose(reset_out_oe) |-> $rose(chip_reset))
        else $error("reset-out without watchdog reset");
    a_out_inside: assert property (reset_out_oe |-> chip_reset)
        else $error("reset-out outside internal reset");
    a_pin_low: assert property (reset_out_pin_n == 1'b0)
        else $error("reset-out pin value not low");
    a_irq_holds: assert property (interval_irq && !ctrl_wr |=> interval_irq)
        else $error("interrupt dropped without clear");
    a_irq_apart: assert property (chip_reset |-> !interval_irq)
        else $error("interrupt during watchdog reset");
    a_rsvd_ones: assert property (
        cpu.rd && cpu.addr == ADDR_RCS_RD |=> rdata[5:0] == RCS_RSVD_ONES)
        else $error("reserved bits not one");
    a_unmapped_zero: assert property (cpu.rd && !mapped |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    // Main scenarios
    c_trip_out: cover property ($rose(chip_reset) && reset_out_oe);
    c_out_end: cover property ($fell(reset_out_oe));
    c_irq: cover property ($rose(interval_irq));
endmodule : guard_timer_checker
bind guard_timer guard_timer_checker i_checker (.clk(clk), .reset(reset), .cpu(cpu),
    .rdata(rdata), .chip_reset(chip_reset), .reset_out_pin_n(reset_out_pin_n),
    .reset_out_oe(reset_out_oe), .interval_irq(interval_irq));
`default_nettype wire

// file: sim/watchdog_interval_timer_bench.sv
/*
 * Self-checking bench for the guard timer: registers, interval and watchdog trips.
 * Assumes the design runs at 10 MHz with one state per clock cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module watchdog_interval_timer_bench
    import guard_timer_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    cpu_req_t cpu = '0;
    logic [7:0] rdata, r;
    logic chip_reset, reset_out_pin_n, reset_out_oe, interval_irq;
    int miscompares = 0, comparisons = 0, cycles = 0, n, m;
    // 100 ns clock
    always #50 clk = ~clk;
    guard_timer i_dut (.clk(clk), .reset(reset), .cpu(cpu), .rdata(rdata),
        .chip_reset(chip_reset), .reset_out_pin_n(reset_out_pin_n),
        .reset_out_oe(reset_out_oe), .interval_irq(interval_irq));
    ////////////////////////////////////////////////////////////////////////////////
    task test_done;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    task check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    // Inputs always move 1 ns after the rising edge
    task step;
        @(posedge clk);
        #1;
    endtask : step
    // A request stands until the next one replaces it or the bus is released
    task wr(input logic w, input logic [15:0] a, input logic [15:0] d);
        cpu = '{1'b0, 1'b1, w, a, d};
        step;
    endtask : wr
    task rd(input logic [15:0] a, input logic [7:0] exp);
        cpu = '{1'b1, 1'b0, 1'b0, a, 16'h0000};
        step;
        check(rdata, exp);
    endtask : rd
    // Arms the watchdog at phi/2 one count short of wrap, then measures both pulses
    task trip;
        wr(1'b1, ADDR_TIMER_WR, 16'hA560);
        wr(1'b1, ADDR_TIMER_WR, 16'h5AFF);
        cpu = '0;
        n = 0;
        m = 0;
        for (int i = 0; i < 8 && chip_reset !== 1'b1; i++) step;
        while (chip_reset === 1'b1 && n < 600)
        begin
            n++;
            m += (reset_out_oe === 1'b1);
            step;
        end
    endtask : trip
    // A hang ends the run as a failure
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            test_done;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        r = 8'($urandom(28819));
        repeat (4) @(posedge clk);
        #1;
        reset = 1'b0;
        rd(ADDR_TCS_RD, TCS_RESET);
        rd(ADDR_CNT_RD, CNT_RESET);
        rd(ADDR_RCS_RD, RCS_RESET);
        rd(ADDR_RESET_WR, 8'h00);
        // Byte write and a wrong password are both ignored
        wr(1'b0, ADDR_TIMER_WR, 16'hA560);
        wr(1'b1, ADDR_TIMER_WR, 16'h3C60);
        rd(ADDR_TCS_RD, TCS_RESET);
        wr(1'b1, ADDR_TIMER_WR, {PASS_COUNT, r});
        rd(ADDR_CNT_RD, 8'h00);
        // A random gap shifts each write against the phi/2 tick; the write must still win
        wr(1'b1, ADDR_TIMER_WR, 16'hA520);
        rd(ADDR_TCS_RD, 8'h38);
        repeat (6)
        begin
            r = 8'($urandom) & 8'h7F;
            if (r[0])
                step;
            wr(1'b1, ADDR_TIMER_WR, {PASS_COUNT, r});
            rd(ADDR_CNT_RD, r);
        end
        // Interval overflow, then clear after reading the flag
        wr(1'b1, ADDR_TIMER_WR, 16'h5AFF);
        cpu = '0;
        for (int i = 0; i < 8 && interval_irq !== 1'b1; i++) step;
        check(interval_irq, 1'b1);
        check(chip_reset, 1'b0);
        rd(ADDR_TCS_RD, 8'hB8);
        wr(1'b1, ADDR_TIMER_WR, 16'hA520);
        check(interval_irq, 1'b0);
        rd(ADDR_RCS_RD, RCS_RESET);
        // Halt, pick phi/32, run 64 cycles: exactly two counts
        wr(1'b1, ADDR_TIMER_WR, 16'hA500);
        wr(1'b1, ADDR_TIMER_WR, 16'hA501);
        wr(1'b1, ADDR_TIMER_WR, 16'hA521);
        cpu = '0;
        repeat (64) step;
        rd(ADDR_CNT_RD, 8'h02);
        wr(1'b1, ADDR_TIMER_WR, 16'hA501);
        wr(1'b1, ADDR_TIMER_WR, 16'hA500);
        repeat (3)
        begin
            r = 8'($urandom);
            wr(1'b1, ADDR_RESET_WR, {PASS_COUNT, r});
            rd(ADDR_RCS_RD, {1'b0, r[6], RCS_RSVD_ONES});
        end
        // Trip with the pin enabled; flag and enable survive the internal reset
        wr(1'b1, ADDR_RESET_WR, 16'h5A40);
        // Regular rewrites keep the armed watchdog from firing
        wr(1'b1, ADDR_TIMER_WR, 16'hA560);
        repeat (4)
        begin
            wr(1'b1, ADDR_TIMER_WR, 16'h5AF8);
            cpu = '0;
            repeat (10) step;
        end
        check(chip_reset, 1'b0);
        trip;
        check(n, INT_RESET_STATES);
        check(m, EXT_RESET_STATES);
        rd(ADDR_RCS_RD, 8'hFF);
        rd(ADDR_TCS_RD, TCS_RESET);
        wr(1'b1, ADDR_RESET_WR, 16'hA500);
        rd(ADDR_RCS_RD, 8'h7F);
        // Trip with the pin disabled, then a pin reset clears the flag
        wr(1'b1, ADDR_RESET_WR, 16'h5A00);
        trip;
        check(m, 0);
        check(n, INT_RESET_STATES);
        // Clear without a prior read of the set flag is ignored
        wr(1'b1, ADDR_RESET_WR, 16'hA500);
        rd(ADDR_RCS_RD, 8'hBF);
        reset = 1'b1;
        step;
        reset = 1'b0;
        rd(ADDR_RCS_RD, RCS_RESET);
        test_done;
    end
endmodule : watchdog_interval_timer_bench
`default_nettype wire
